/* core/mode_privilege_control.sv */
// Mode and privilege control: status word, cross-space moves, returns, gated privileged ops
`timescale 1ns/1ps
`default_nettype none
// What this block does
// R1 - Status bits 13:12 hold previous space
// R2 - Cross moves link current stack, previous space
// R3 - Index constants fetched from current space
// R4 - Each mode has separate full I and D maps
// R5 - Decode four distinct cross-space moves
// R6 - Returns reload saved PC and status word
// R7 - Fetches use I map, data uses D map
// R8 - Privileged ops only in kernel mode
// R9 - Unprivileged reset and level set do nothing
// R10 - Unprivileged halt starts trap service instead
// R11 - Previous field 11 confines moves to user
// R12 - Map entries hold relocation and access code
// R13 - Read-only pages refuse writes
// R14 - Each mode translates through own maps only
// R15 - Bits 15:14 pick map and stack pointer
// R16 - Bit 11 picks general register set
// R17 - Mode codes 00 kernel, 01 middle, 10 invalid
// R18 - Non-resident or read-only write aborts instruction
module mode_privilege_control
    import mpc_pkg::*;
#(
    parameter int MAP_ENTRIES = 64
) (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_op_valid,
    input wire mpc_op_t i_op,
    input wire logic [VA_W-1:0] i_op_vaddr,
    input wire logic [VA_W-1:0] i_op_wdata,
    input wire logic [VA_W-1:0] i_restore_pc,
    input wire logic [PS_W-1:0] i_restore_ps,
    input wire logic [PRI_W-1:0] i_spl_level,
    input wire logic i_trap_ps_load,
    input wire logic [PS_W-1:0] i_trap_ps,
    input wire logic i_ref_valid,
    input wire logic [VA_W-1:0] i_ref_vaddr,
    input wire logic i_ref_fetch,
    input wire logic i_ref_write,
    input wire logic [VA_W-1:0] i_ref_wdata,
    input wire logic i_map_we,
    input wire logic [MAP_IDX_W-1:0] i_map_index,
    input wire logic [RELOC_W-1:0] i_map_reloc,
    input wire mpc_acc_t i_map_acc,
    input wire logic i_mem_ack,
    input wire logic [VA_W-1:0] i_mem_rdata,
    output logic [PS_W-1:0] o_ps,
    output wire logic [1:0] o_cur_mode,
    output wire logic [1:0] o_prev_mode,
    output wire logic [1:0] o_stack_sel,
    output wire logic o_reg_set,
    output logic o_busy,
    output logic [VA_W-1:0] o_pc,
    output logic o_pc_load,
    output logic o_bus_reset,
    output logic o_halt,
    output logic o_trap_req,
    output logic o_abort,
    output logic o_op_done,
    output logic o_ref_done,
    output logic [VA_W-1:0] o_ref_rdata,
    output logic o_push_valid,
    output logic [VA_W-1:0] o_push_data,
    output logic o_mem_req,
    output logic o_mem_we,
    output logic [PA_W-1:0] o_mem_paddr,
    output logic [VA_W-1:0] o_mem_wdata
);

    typedef enum logic [1:0] {ST_IDLE, ST_XLATE, ST_MEM} mpc_state_t;

    mpc_state_t state;  // Reference sequencer
    logic [1:0] sel_mode;  // Mode whose map translates the reference
    logic sel_space;  // I or D space of the reference
    logic sel_write;  // Reference writes memory
    logic sel_cross;  // Reference belongs to a cross-space move
    logic sel_push;  // Read result goes to the current stack
    logic [VA_W-1:0] sel_vaddr;  // Virtual address held for lookup
    logic [VA_W-1:0] sel_wdata;  // Write data held for the transfer
    logic is_kernel;  // Current mode is the privileged one
    logic take_op;  // Operation accepted this cycle
    logic take_cross;  // Accepted operation is a cross-space move
    logic take_ref;  // Ordinary reference accepted this cycle
    logic fault;  // Lookup of the held reference faults
    mpc_acc_t map_acc;  // Access code of the looked-up page
    logic [PA_W-1:0] map_paddr;  // Physical address of the looked-up page
    logic [PS_W-1:0] ret_ps;  // Status word a return would install

    // Mode fields straight off the status word
    assign o_cur_mode = o_ps[PS_CUR_HI:PS_CUR_LO]; // R15
    assign o_prev_mode = o_ps[PS_PREV_HI:PS_PREV_LO]; // R1
    assign o_stack_sel = o_ps[PS_CUR_HI:PS_CUR_LO]; // R15
    assign o_reg_set = o_ps[PS_REGSET]; // R16

    assign is_kernel = (o_cur_mode == MODE_KERNEL); // R8 R17
    assign take_op = (state == ST_IDLE) && i_op_valid && (i_op != OP_NONE);
    assign take_cross = take_op && op_is_cross(i_op); // R5
    // Operations win over references; the reference simply waits a turn
    assign take_ref = (state == ST_IDLE) && i_ref_valid && !take_op;

    // Unprivileged returns may not raise privilege: mode bits only gain ones, set and level stay
    assign ret_ps = is_kernel ? i_restore_ps // R6
        : ((i_restore_ps & ~PS_KEEP_MASK) | (o_ps & PS_KEEP_MASK) | (o_ps & PS_MODE_MASK)); // R8

    mpc_page_map #(
        .ENTRIES(MAP_ENTRIES)
    ) u_map (
        .i_mclk(i_mclk),
        .i_reset_n(i_reset_n),
        .i_map_we(i_map_we),
        .i_map_index(i_map_index),
        .i_map_reloc(i_map_reloc),
        .i_map_acc(i_map_acc),
        .i_mode(sel_mode),
        .i_space(sel_space),
        .i_vaddr(sel_vaddr),
        .o_acc(map_acc),
        .o_paddr(map_paddr)
    );

    mpc_access_check u_check (
        .i_mode(sel_mode),
        .i_acc(map_acc),
        .i_write(sel_write),
        .o_fault(fault)
    );

    // Status word: trap service load first, then returns, then level set
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_ps <= PS_RESET;
        end else if (i_trap_ps_load) begin
            o_ps <= i_trap_ps;
        end else if (take_op && (i_op == OP_RTI || i_op == OP_RTT)) begin
            o_ps <= ret_ps; // R6
        end else if (take_op && i_op == OP_SPL && is_kernel) begin
            o_ps[PS_PRI_HI:PS_PRI_LO] <= i_spl_level; // R9
        end
    end

    // Program counter reload on returns
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_pc <= '0;
        end else if (take_op && (i_op == OP_RTI || i_op == OP_RTT)) begin
            o_pc <= i_restore_pc; // R6
        end
    end

    // Reference sequencer and held request
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state <= ST_IDLE;
            sel_mode <= MODE_KERNEL;
            sel_space <= SPACE_D;
            sel_write <= 1'b0;
            sel_cross <= 1'b0;
            sel_push <= 1'b0;
            sel_vaddr <= '0;
            sel_wdata <= '0;
            o_busy <= 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (take_cross) begin
                        // Address was formed from current-space fetches; only the transfer is remote
                        state <= ST_XLATE; // R3
                        sel_mode <= o_prev_mode; // R2 R11
                        sel_space <= op_is_ispace(i_op) ? SPACE_I : SPACE_D; // R5
                        sel_write <= op_is_mtp(i_op); // R5
                        sel_push <= !op_is_mtp(i_op); // R2
                        sel_cross <= 1'b1;
                        sel_vaddr <= i_op_vaddr;
                        sel_wdata <= i_op_wdata; // R2
                        o_busy <= 1'b1;
                    end else if (take_ref) begin
                        state <= ST_XLATE;
                        sel_mode <= o_cur_mode; // R14 R15
                        // Fetches, address constants included, go through the I map
                        sel_space <= i_ref_fetch ? SPACE_I : SPACE_D; // R7 R3
                        sel_write <= i_ref_write && !i_ref_fetch;
                        sel_push <= 1'b0;
                        sel_cross <= 1'b0;
                        sel_vaddr <= i_ref_vaddr;
                        sel_wdata <= i_ref_wdata;
                        o_busy <= 1'b1;
                    end
                end
                ST_XLATE: begin
                    // A fault drops the reference before memory sees it
                    state <= fault ? ST_IDLE : ST_MEM; // R18
                    o_busy <= !fault;
                end
                ST_MEM: begin
                    if (i_mem_ack) begin
                        state <= ST_IDLE;
                        o_busy <= 1'b0;
                    end
                end
            endcase
        end
    end

    // Memory request, held until acknowledged
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_mem_req <= 1'b0;
            o_mem_we <= 1'b0;
            o_mem_paddr <= '0;
            o_mem_wdata <= '0;
        end else if (state == ST_XLATE && !fault) begin
            o_mem_req <= 1'b1;
            o_mem_we <= sel_write; // R13
            o_mem_paddr <= map_paddr; // R14
            o_mem_wdata <= sel_wdata;
        end else if (state == ST_MEM && i_mem_ack) begin
            o_mem_req <= 1'b0;
            o_mem_we <= 1'b0;
        end
    end

    // One-cycle event pulses; these fall back to zero every cycle
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_pc_load <= 1'b0;
            o_bus_reset <= 1'b0;
            o_halt <= 1'b0;
            o_trap_req <= 1'b0;
            o_abort <= 1'b0;
            o_op_done <= 1'b0;
            o_ref_done <= 1'b0;
            o_push_valid <= 1'b0;
        end else begin
            o_pc_load <= take_op && (i_op == OP_RTI || i_op == OP_RTT); // R6
            o_bus_reset <= take_op && (i_op == OP_RESET) && is_kernel; // R8 R9
            o_halt <= take_op && (i_op == OP_HALT) && is_kernel; // R8
            // Halt outside kernel hands control to the executive, not a stop
            o_trap_req <= take_op && (i_op == OP_HALT) && !is_kernel; // R10
            o_abort <= (state == ST_XLATE) && fault; // R18
            o_op_done <= (take_op && !take_cross)
                || (state == ST_MEM && i_mem_ack && sel_cross); // R9
            o_ref_done <= (state == ST_MEM) && i_mem_ack && !sel_cross;
            o_push_valid <= (state == ST_MEM) && i_mem_ack && sel_push; // R2
        end
    end

    // Read data capture for the requester or the current stack
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_ref_rdata <= '0;
            o_push_data <= '0;
        end else if (state == ST_MEM && i_mem_ack) begin
            if (sel_push) begin
                o_push_data <= i_mem_rdata; // R2
            end else if (!sel_cross) begin
                o_ref_rdata <= i_mem_rdata;
            end
        end
    end

    // Checks on the block's own behaviour
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_reset_n);

    sequence s_op_no_trap(mpc_op_t op);
        take_op && i_op == op && !i_trap_ps_load;
    endsequence

    sequence s_read_ack;
        state == ST_MEM && i_mem_ack && sel_push;
    endsequence

    a_spl_user_inert: // R9
    assert property (s_op_no_trap(OP_SPL) and !is_kernel |=> $stable(o_ps) && o_op_done)
        else $error("level set changed status outside kernel");

    a_halt_user_trap: // R10
    assert property (take_op && i_op == OP_HALT && !is_kernel |=> o_trap_req && !o_halt)
        else $error("unprivileged halt did not trap");

    a_reset_kernel_only: // R8
    assert property (o_bus_reset |-> $past(is_kernel) && $past(i_op) == OP_RESET)
        else $error("bus reset outside kernel");

    a_ro_write_abort: // R13
    assert property (state == ST_XLATE && sel_write && map_acc == ACC_RO && sel_mode != MODE_BAD
        |=> o_abort && !o_mem_req && state == ST_IDLE)
        else $error("write to read-only page not aborted");

    a_fetch_ispace: // R7
    assert property (take_ref && i_ref_fetch |=> sel_space == SPACE_I && sel_mode == $past(o_cur_mode))
        else $error("fetch not routed through current I map");

    a_cross_prev_map: // R2
    assert property (take_cross |=> sel_mode == $past(o_prev_mode) && sel_cross ##1 state != ST_XLATE)
        else $error("cross move not translated in previous mode");

    a_return_restore: // R6
    assert property (s_op_no_trap(OP_RTI) and is_kernel |=> o_ps == $past(i_restore_ps, 1)
        && o_pc == $past(i_restore_pc) && o_pc_load)
        else $error("return did not restore context");

    a_bad_mode_abort: // R17
    assert property (state == ST_XLATE && sel_mode == MODE_BAD |=> o_abort ##1 !o_abort)
        else $error("invalid mode reference not aborted");

    a_mfp_push: // R2
    assert property (s_read_ack |=> o_push_valid && o_push_data == $past(i_mem_rdata) && o_op_done)
        else $error("move from previous did not push the word");

    a_user_confined: // R11
    assert property (take_cross && o_prev_mode == MODE_USER |=> sel_mode == MODE_USER)
        else $error("user previous field left user space");

endmodule
`default_nettype wire

/* core/mpc_access_check.sv */
// Access fault check for one translated reference
`timescale 1ns/1ps
`default_nettype none
module mpc_access_check
    import mpc_pkg::*;
(
    input wire logic [1:0] i_mode,
    input wire mpc_acc_t i_acc,
    input wire logic i_write,
    output logic o_fault
);

    // Non-resident pages, writes to read-only pages and the unused mode code all abort
    always_comb begin
        o_fault = 1'b0;
        if (i_mode == MODE_BAD) begin
            o_fault = 1'b1; // R17
        end else if (i_acc == ACC_NONRES) begin
            o_fault = 1'b1; // R18
        end else if (i_acc == ACC_RO && i_write) begin
            o_fault = 1'b1; // R13
        end
    end

endmodule
`default_nettype wire

/* core/mpc_page_map.sv */
// Per-mode, per-space page map: relocation and access code storage with lookup
`timescale 1ns/1ps
`default_nettype none
module mpc_page_map
    import mpc_pkg::*;
#(
    parameter int ENTRIES = 64
) (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_map_we,
    input wire logic [MAP_IDX_W-1:0] i_map_index,
    input wire logic [RELOC_W-1:0] i_map_reloc,
    input wire mpc_acc_t i_map_acc,
    input wire logic [1:0] i_mode,
    input wire logic i_space,
    input wire logic [VA_W-1:0] i_vaddr,
    output mpc_acc_t o_acc,
    output logic [PA_W-1:0] o_paddr
);

    logic [RELOC_W-1:0] reloc_mem [ENTRIES];  // Relocation per entry
    mpc_acc_t acc_mem [ENTRIES];  // Access code per entry
    logic [MAP_IDX_W-1:0] rd_index;  // Entry picked by mode, space, page

    // Only the mode's own entries are ever consulted, so one mode cannot reach another's pages
    assign rd_index = {i_mode, i_space, i_vaddr[VA_W-1:OFF_W]}; // R14 R4

    // Entry storage; every page starts out non-resident
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            for (int k = 0; k < ENTRIES; k++) begin
                reloc_mem[k] <= '0;
                acc_mem[k] <= ACC_NONRES; // R12
            end
        end else if (i_map_we) begin
            reloc_mem[i_map_index] <= i_map_reloc; // R12
            acc_mem[i_map_index] <= i_map_acc;
        end
    end

    // Lookup: block base plus page offset
    always_comb begin
        o_acc = acc_mem[rd_index];
        o_paddr = PA_W'({reloc_mem[rd_index], BLK_ZERO}) + PA_W'(i_vaddr[OFF_W-1:0]);
    end

endmodule
`default_nettype wire

/* shared/mpc_pkg.sv */
// Constants, types and decode helpers for the mode and privilege control block
package mpc_pkg;

    // Status word layout
    localparam int PS_W = 16;
    localparam int PS_CUR_HI = 15;
    localparam int PS_CUR_LO = 14;
    localparam int PS_PREV_HI = 13;
    localparam int PS_PREV_LO = 12;
    localparam int PS_REGSET = 11;
    localparam int PS_PRI_HI = 7;
    localparam int PS_PRI_LO = 5;
    localparam int PRI_W = 3;
    localparam logic [15:0] PS_RESET = 16'h0000;
    // Mode fields, ORed in from the current word when a return runs unprivileged
    localparam logic [15:0] PS_MODE_MASK = 16'hF000;
    // Register set and priority, untouchable outside the most privileged mode
    localparam logic [15:0] PS_KEEP_MASK = 16'h08E0;

    // Mode codes
    localparam logic [1:0] MODE_KERNEL = 2'h0;
    localparam logic [1:0] MODE_SUPER = 2'h1;
    localparam logic [1:0] MODE_BAD = 2'h2;
    localparam logic [1:0] MODE_USER = 2'h3;

    // Address widths
    localparam int VA_W = 16;
    localparam int PAGE_W = 3;
    localparam int OFF_W = 13;
    localparam int RELOC_W = 16;
    localparam int BLK_W = 6;
    localparam int PA_W = 22;
    localparam int MAP_IDX_W = 6;
    localparam logic [BLK_W-1:0] BLK_ZERO = 6'h00;

    // Space select
    localparam logic SPACE_D = 1'h0;
    localparam logic SPACE_I = 1'h1;

    // Page access codes
    typedef enum logic [1:0] {ACC_NONRES, ACC_RO, ACC_RW} mpc_acc_t;

    // Operation classes handed over by the instruction decoder
    typedef enum logic [3:0] {
        OP_NONE, OP_MOVE_TO_PREV_INSTR_SPACE, OP_MOVE_TO_PREV_DATA_SPACE, OP_MOVE_FROM_PREV_INSTR_SPACE, OP_MOVE_FROM_PREV_DATA_SPACE,
        OP_RTI, OP_RTT, OP_SPL, OP_RESET, OP_HALT
    } mpc_op_t;

    // Any of the four cross-space moves
    function automatic logic op_is_cross(input mpc_op_t op);
        return (op == OP_MOVE_TO_PREV_INSTR_SPACE) || (op == OP_MOVE_TO_PREV_DATA_SPACE) || (op == OP_MOVE_FROM_PREV_INSTR_SPACE) || (op == OP_MOVE_FROM_PREV_DATA_SPACE);
    endfunction

    // Moves toward the previous space write there
    function automatic logic op_is_mtp(input mpc_op_t op);
        return (op == OP_MOVE_TO_PREV_INSTR_SPACE) || (op == OP_MOVE_TO_PREV_DATA_SPACE);
    endfunction

    // Moves that address the previous instruction space
    function automatic logic op_is_ispace(input mpc_op_t op);
        return (op == OP_MOVE_TO_PREV_INSTR_SPACE) || (op == OP_MOVE_FROM_PREV_INSTR_SPACE);
    endfunction

endpackage

/* testbench/mpc_mem_model.sv */
// Behavioural physical memory behind the translated bus
`timescale 1ns/1ps
`default_nettype none
module mpc_mem_model (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_req,
    input wire logic i_we,
    input wire logic [21:0] i_paddr,
    input wire logic [15:0] i_wdata,
    input wire logic [3:0] i_wait,
    output logic o_ack,
    output logic [15:0] o_rdata
);
    logic [15:0] store [int]; // Words written so far
    logic [3:0] cnt; // Cycles the current request has waited

    // Unwritten words read back as a pattern made from their address
    function automatic logic [15:0] fill(input logic [21:0] a);
        return a[15:0] ^ {10'h000, a[21:16]};
    endfunction

    // Answer after i_wait cycles; read data only holds in the ack cycle,
    // so a late sample of it shows up as a wrong word
    always @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_ack <= 1'b0;
            cnt <= 4'h0;
            o_rdata <= 16'h5a5a;
        end else if (o_ack) begin
            o_ack <= 1'b0;
            cnt <= 4'h0;
            o_rdata <= ~o_rdata;
        end else if (i_req === 1'b1 && cnt >= i_wait) begin
            o_ack <= 1'b1;
            if (i_we) begin
                store[int'(i_paddr)] = i_wdata;
            end
            o_rdata <= store.exists(int'(i_paddr)) ? store[int'(i_paddr)] : fill(i_paddr);
        end else begin
            cnt <= (i_req === 1'b1) ? cnt + 4'h1 : 4'h0;
            o_rdata <= ~o_rdata;
        end
    end
endmodule
`default_nettype wire

/* testbench/tb_mode_privilege_control.sv */
// Self-checking bench: issues ops and references, checks results in issue order
`timescale 1ns/1ps
`default_nettype none
module tb_mode_privilege_control;
    import mpc_pkg::*;
    logic i_mclk, i_reset_n, i_op_valid, i_trap_ps_load, i_ref_valid, i_ref_fetch, i_ref_write;
    logic i_map_we, i_mem_ack, o_reg_set, o_pc_load, o_bus_reset, o_halt, o_trap_req, o_abort;
    logic o_op_done, o_ref_done, o_push_valid, o_mem_req, o_mem_we, o_busy;
    logic [1:0] o_cur_mode, o_prev_mode, o_stack_sel; // Mode slices shown on their own ports
    mpc_op_t i_op;
    mpc_acc_t i_map_acc;
    logic [15:0] i_op_vaddr, i_op_wdata, i_restore_pc, i_restore_ps, i_trap_ps, i_ref_vaddr, i_ref_wdata;
    logic [15:0] i_map_reloc, i_mem_rdata, o_ps, o_pc, o_ref_rdata, o_push_data, o_mem_wdata;
    logic [2:0] i_spl_level;
    logic [5:0] i_map_index;
    logic [21:0] o_mem_paddr;
    logic [3:0] mem_wait; // Memory answer delay
    logic [21:0] expq[$]; // Expected {flags, data} per result, oldest first
    logic [21:0] obs; // Result seen this cycle
    logic [15:0] w, rpc; // Word moved across spaces, last restored pc
    integer seed = 32'h4ab8;
    int mismatches = 0;
    int n_checks = 0;

    mode_privilege_control i_mode_privilege_control (
        .i_mclk, .i_reset_n, .i_op_valid, .i_op, .i_op_vaddr, .i_op_wdata, .i_restore_pc, .i_restore_ps,
        .i_spl_level, .i_trap_ps_load, .i_trap_ps, .i_ref_valid, .i_ref_vaddr, .i_ref_fetch, .i_ref_write,
        .i_ref_wdata, .i_map_we, .i_map_index, .i_map_reloc, .i_map_acc, .i_mem_ack, .i_mem_rdata, .o_ps,
        .o_cur_mode, .o_prev_mode, .o_stack_sel, .o_reg_set, .o_busy, .o_pc, .o_pc_load,
        .o_bus_reset, .o_halt, .o_trap_req, .o_abort, .o_op_done, .o_ref_done, .o_ref_rdata, .o_push_valid,
        .o_push_data, .o_mem_req, .o_mem_we, .o_mem_paddr, .o_mem_wdata);

    mpc_mem_model i_mpc_mem_model (.i_mclk, .i_reset_n, .i_req(o_mem_req), .i_we(o_mem_we),
        .i_paddr(o_mem_paddr), .i_wdata(o_mem_wdata), .i_wait(mem_wait), .o_ack(i_mem_ack),
        .o_rdata(i_mem_rdata));

    // 20 MHz clock
    initial begin
        i_mclk = 1'b0;
        forever #25 i_mclk = ~i_mclk;
    end

    // Word the memory returns for an untouched location of a page
    function automatic logic [15:0] rd(input logic [15:0] rel, input logic [15:0] va);
        logic [21:0] a;
        a = {rel, 6'h00} + {9'h000, va[12:0]};
        return a[15:0] ^ {10'h000, a[21:16]};
    endfunction

    task automatic chk(input logic [21:0] seen, input logic [21:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        if (mismatches == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Bounded wait until every expected result has been seen
    task automatic drain();
        int n;
        for (n = 0; n < 40 && expq.size() != 0; n++) @(posedge i_mclk);
        if (expq.size() != 0) begin
            mismatches++;
            conclude();
        end
    endtask

    // One operation; x serves as store word, restored status or level
    task automatic op(input mpc_op_t k, input logic [15:0] va, input logic [15:0] x, input logic [21:0] e);
        @(posedge i_mclk);
        rpc = 16'($random(seed));
        i_op_valid <= 1'b1;
        i_op <= k;
        i_op_vaddr <= va;
        i_op_wdata <= x;
        i_restore_ps <= x;
        i_spl_level <= x[2:0];
        i_restore_pc <= rpc;
        expq.push_back(e);
        @(posedge i_mclk);
        i_op_valid <= 1'b0;
        drain();
    endtask

    // One ordinary reference
    task automatic rf(input logic f, input logic wr, input logic [15:0] va, input logic [21:0] e);
        @(posedge i_mclk);
        i_ref_valid <= 1'b1;
        i_ref_fetch <= f;
        i_ref_write <= wr;
        i_ref_vaddr <= va;
        i_ref_wdata <= 16'($random(seed));
        expq.push_back(e);
        @(posedge i_mclk);
        i_ref_valid <= 1'b0;
        drain();
    endtask

    task automatic mw(input logic [5:0] idx, input logic [15:0] rel, input mpc_acc_t acc);
        @(posedge i_mclk);
        i_map_we <= 1'b1;
        i_map_index <= idx;
        i_map_reloc <= rel;
        i_map_acc <= acc;
        @(posedge i_mclk);
        i_map_we <= 1'b0;
    endtask

    // Trap service loads a new status word
    task automatic tl(input logic [15:0] ps);
        @(posedge i_mclk);
        i_trap_ps_load <= 1'b1;
        i_trap_ps <= ps;
        @(posedge i_mclk);
        i_trap_ps_load <= 1'b0;
    endtask

    // Each result pulse retires the oldest expectation; a stray one fails
    always @(posedge i_mclk) begin
        if (i_reset_n === 1'b1 && (o_op_done | o_abort | o_ref_done) === 1'b1) begin
            obs = {o_abort, o_bus_reset, o_halt, o_trap_req, o_pc_load, o_push_valid,
                   o_push_valid ? o_push_data : (o_ref_done ? o_ref_rdata : o_ps)};
            chk(obs, expq.size() > 0 ? expq.pop_front() : ~obs);
            // Every result ends the sequencer's work, so busy must already be low
            chk({21'h00_0000, o_busy}, 22'h00_0000);
        end
    end

    initial begin
        int i;
        logic [15:0] va;
        i_reset_n = 1'b0;
        i_op_valid = 1'b0;
        i_op = OP_NONE;
        i_op_vaddr = 16'h0000;
        i_op_wdata = 16'h0000;
        i_restore_pc = 16'h0000;
        i_restore_ps = 16'h0000;
        i_spl_level = 3'h0;
        i_trap_ps_load = 1'b0;
        i_trap_ps = 16'h0000;
        i_ref_valid = 1'b0;
        i_ref_vaddr = 16'h0000;
        i_ref_fetch = 1'b0;
        i_ref_write = 1'b0;
        i_ref_wdata = 16'h0000;
        i_map_we = 1'b0;
        i_map_index = 6'h00;
        i_map_reloc = 16'h0000;
        i_map_acc = ACC_NONRES;
        mem_wait = 4'h0;
        repeat (3) @(posedge i_mclk);
        i_reset_n <= 1'b1;
        chk({5'h00, o_reg_set, o_ps}, 22'h00_0000);
        op(OP_SPL, 16'h0000, 16'h0005, {6'h00, 16'h00A0});
        op(OP_RESET, 16'h0000, 16'h0000, {6'h10, 16'h00A0});
        // Kernel I/D page 0, user D pages 0..2, user I page 2; user I page 3 stays absent
        mw(6'h08, 16'h0040, ACC_RW);
        mw(6'h00, 16'h0080, ACC_RW);
        mw(6'h30, 16'h0300, ACC_RW);
        mw(6'h31, 16'h0100, ACC_RW);
        mw(6'h32, 16'h0400, ACC_RO);
        mw(6'h3A, 16'h0200, ACC_RO);
        tl(16'h3000);
        // Same address through I and D maps, memory slowing each round
        for (i = 0; i < 4; i++) begin
            va = {3'h0, 13'($random(seed))};
            mem_wait <= 4'(i);
            rf(1'b1, 1'b1, va, {6'h00, rd(16'h0040, va)});
            rf(1'b0, 1'b0, va, {6'h00, rd(16'h0080, va)});
        end
        w = 16'($random(seed));
        op(OP_MOVE_TO_PREV_DATA_SPACE, 16'h2004, w, {6'h00, 16'h3000});
        mem_wait <= 4'h5;
        op(OP_MOVE_FROM_PREV_DATA_SPACE, 16'h2004, 16'h0000, {6'h01, w});
        op(OP_MOVE_FROM_PREV_INSTR_SPACE, 16'h4008, 16'h0000, {6'h01, rd(16'h0200, 16'h4008)});
        op(OP_MOVE_TO_PREV_INSTR_SPACE, 16'h4008, w, {6'h20, 16'h3000});
        op(OP_MOVE_FROM_PREV_INSTR_SPACE, 16'h6000, 16'h0000, {6'h20, 16'h3000});
        mem_wait <= 4'h1;
        op(OP_RTI, 16'h0000, 16'hF000, {6'h02, 16'hF000});
        chk({6'h00, o_pc}, {6'h00, rpc});
        // Restored word selects user map, user stack and user as previous space
        chk({15'h0000, o_cur_mode, o_prev_mode, o_stack_sel, o_reg_set}, {15'h0000, 7'h7E});
        rf(1'b0, 1'b0, 16'h0010, {6'h00, rd(16'h0300, 16'h0010)});
        rf(1'b0, 1'b1, 16'h4000, {6'h20, 16'hF000});
        op(OP_SPL, 16'h0000, 16'h0007, {6'h00, 16'hF000});
        op(OP_RESET, 16'h0000, 16'h0000, {6'h00, 16'hF000});
        op(OP_HALT, 16'h0000, 16'h0000, {6'h04, 16'hF000});
        op(OP_RTT, 16'h0000, 16'h08E0, {6'h02, 16'hF000});
        op(OP_MOVE_FROM_PREV_DATA_SPACE, 16'h2004, 16'h0000, {6'h01, w});
        tl(16'h8000);
        rf(1'b1, 1'b0, 16'h0000, {6'h20, 16'h8000});
        tl(16'h0800);
        op(OP_SPL, 16'h0000, 16'h0002, {6'h00, 16'h0840});
        op(OP_HALT, 16'h0000, 16'h0000, {6'h08, 16'h0840});
        // Kernel word with bit 11 set: kernel stack, alternate register set
        chk({15'h0000, o_cur_mode, o_prev_mode, o_stack_sel, o_reg_set}, {15'h0000, 7'h01});
        conclude();
    end
endmodule
`default_nettype wire
